// File: include/gapc_pkg.sv
// package: constants, types and register map of the alarm and parameter control block
package gapc_pkg;
  // ****************************************************************
  // timing and history depth
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MS_PERIOD_PS  = 1000000000;
  localparam int MS_CYC        = MS_PERIOD_PS / CLK_PERIOD_PS;
  localparam int CLR_CYC       = 16;
  localparam int HIST_DEPTH    = 10;
  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK   = 8'h04;
  localparam logic [7:0] OFS_ALARM  = 8'h08;
  localparam logic [7:0] OFS_WARN   = 8'h0c;
  localparam logic [7:0] OFS_HSEL   = 8'h10;
  localparam logic [7:0] OFS_HDATA  = 8'h14;
  localparam logic [7:0] OFS_SCAN   = 8'h18;
  localparam logic [7:0] OFS_CONN   = 8'h1c;
  localparam logic [7:0] OFS_CACT   = 8'h20;
  localparam logic [7:0] OFS_NAV    = 8'h24;
  // ****************************************************************
  // status bit positions, reset values and the deepest menu level
  // ****************************************************************
  localparam int ST_ALARM  = 0;
  localparam int ST_WARN   = 1;
  localparam int ST_LINK   = 2;
  localparam int ST_REFUSE = 3;
  localparam int ST_CLRD   = 4;
  localparam int ST_SCAN   = 5;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic       EDIT_RST = 1'b1;
  localparam logic [1:0] LVL_MAX  = 2'h3;
  // ****************************************************************
  // alarm and warning codes
  // ****************************************************************
  localparam logic [7:0] ALM_NVM   = 8'ha1;
  localparam logic [7:0] ALM_SWSET = 8'he3;
  localparam logic [7:0] ALM_RS485 = 8'he4;
  localparam logic [7:0] ALM_NODE  = 8'he6;
  localparam logic [7:0] WRN_RS485 = 8'he4;
  localparam logic [7:0] WRN_TOUT  = 8'he5;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_MON   = 3'b001,
    MODE_PARAM = 3'b010,
    MODE_COPY  = 3'b100
  } gapc_mode_t;
  typedef enum logic [3:0] {
    DISP_NONE = 4'b0001,
    DISP_COMM = 4'b0010,
    DISP_BUSY = 4'b0100,
    DISP_LOCK = 4'b1000
  } gapc_disp_t;
  typedef struct packed {
    logic       valid;
    logic       warn;
    logic [7:0] code;
  } gapc_ent_t;
  typedef struct packed {
    logic key_set;
    logic key_esc;
    logic key_mode;
    logic lock_toggle;
    logic clr_alarm;
    logic clr_warn;
  } gapc_keys_t;
  typedef struct packed {
    gapc_mode_t mode;
    logic [1:0] level;
    gapc_disp_t disp;
    logic       lock;
    logic       clr_visible;
    logic       clr_busy;
    logic       mem_busy;
  } gapc_view_t;
endpackage

// File: rtl/gapc_top.sv
// alarm, warning and parameter access control of the setter port
`timescale 1ns/1ps
`default_nettype none
module gapc_top
  import gapc_pkg::*;
#(
  parameter int MS_CYCLES = gapc_pkg::MS_CYC
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              link_fail,
  input  wire gapc_pkg::gapc_keys_t keys,
  input  wire logic              mem_start,
  input  wire logic              mem_done,
  input  wire logic [3:0]        alarm_evt,
  input  wire logic [1:0]        warn_evt,
  input  wire logic              scan_done,
  input  wire logic [15:0]       boot_conn,
  output logic                   rs485_halt,
  output logic [15:0]            conn_en,
  output gapc_pkg::gapc_view_t   view
);
  import gapc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]             fsync;
    logic                   link_d;
    logic                   started;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   irq;
    logic [5:0]             sts;
    logic [5:0]             msk;
    logic                   alm_on;
    logic [7:0]             alm_code;
    logic                   wrn_on;
    logic [7:0]             wrn_code;
    gapc_ent_t [HIST_DEPTH-1:0] hist;
    logic [3:0]             hsel;
    logic [15:0]            ms_div;
    logic [15:0]            scan_cnt;
    logic [15:0]            scan_ms;
    logic [15:0]            conn_st;
    logic [15:0]            conn_act;
    logic [15:0]            conn_out;
    logic                   halt;
    logic                   edit_en;
    logic                   busy;
    gapc_mode_t             mode;
    logic [1:0]             lvl;
    gapc_disp_t             disp;
    logic                   clr_act;
    logic                   clr_warn;
    logic [3:0]             clr_cnt;
  } gapc_state_t;

  gapc_state_t s_reg;
  gapc_state_t s_next;
  logic [1:0]  rst_sync_reg;
  logic        rstn_i;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // priority pick of the alarm cause, lowest index wins
  function automatic logic [7:0] gapc_alm_code(input logic [3:0] v);
    logic [7:0] c;
    c = ALM_NODE;
    if (v[2]) c = ALM_RS485;
    if (v[1]) c = ALM_SWSET;
    if (v[0]) c = ALM_NVM;
    return c;
  endfunction

  // byte offset match, used for write decode; reads decode with a case on paddr
  function automatic logic gapc_hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  // async assert, two-stage synchronous release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rstn_i = rst_sync_reg[1];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic       setup;
    logic       wr;
    logic [5:0] ev;
    logic [5:0] w1c;
    logic       lock;
    logic       link;
    logic       tick;
    logic       top;
    logic       rec;
    gapc_ent_t  ent;
    setup = 1'b0;
    wr    = 1'b0;
    ev    = 6'h00;
    w1c   = 6'h00;
    lock  = 1'b0;
    link  = 1'b0;
    tick  = 1'b0;
    top   = 1'b0;
    rec   = 1'b0;
    ent   = '0;
    s_next = s_reg;

    // link fault pin: first stage feeds only the second
    s_next.fsync  = {s_reg.fsync[0], link_fail};
    link          = s_reg.fsync[1];
    s_next.link_d = link;
    lock          = ~s_reg.edit_en;
    top           = s_reg.lvl == 2'h0;

    // parameters load from the boot image once after each reset
    if (!s_reg.started) begin
      s_next.started  = 1'b1;
      s_next.conn_st  = boot_conn;
      s_next.conn_act = boot_conn;
    end

    // apb: data and ready are registered in setup, taken in access
    setup          = psel & ~penable;
    wr             = psel & penable & s_reg.pready & pwrite;
    s_next.pready  = setup;
    s_next.pslverr = 1'b0;
    if (setup) begin
      s_next.prdata = 32'h0;
      case (paddr)
        OFS_STATUS: s_next.prdata = {26'h0, s_reg.sts};
        OFS_MASK:   s_next.prdata = {26'h0, s_reg.msk};
        OFS_ALARM:  s_next.prdata = {23'h0, s_reg.alm_on, s_reg.alm_code};
        OFS_WARN:   s_next.prdata = {23'h0, s_reg.wrn_on, s_reg.wrn_code};
        OFS_HSEL:   s_next.prdata = {28'h0, s_reg.hsel};
        OFS_HDATA: begin
          if (s_reg.hsel < 4'(HIST_DEPTH)) begin
            s_next.prdata = {22'h0, s_reg.hist[s_reg.hsel]};
          end
        end
        OFS_SCAN:   s_next.prdata = {16'h0, s_reg.scan_ms};
        OFS_CONN:   s_next.prdata = {16'h0, s_reg.conn_st};
        OFS_CACT:   s_next.prdata = {16'h0, s_reg.conn_act};
        OFS_NAV:    s_next.prdata = {16'h0, view_bits(s_reg)};
        default:    s_next.pslverr = 1'b1;
      endcase
    end
    if (wr && gapc_hit(paddr, OFS_STATUS)) w1c = pwdata[5:0];
    if (wr && gapc_hit(paddr, OFS_MASK)) s_next.msk = pwdata[5:0];
    if (wr && gapc_hit(paddr, OFS_HSEL)) s_next.hsel = pwdata[3:0];
    // stored only; the running copy never takes it and reloads from boot_conn at the next reset
    if (wr && gapc_hit(paddr, OFS_CONN) && s_reg.edit_en) begin
      s_next.conn_st = pwdata[15:0];
    end

    // alarms latch until reset; no command clears them
    if (|alarm_evt) begin
      ev[ST_ALARM] = 1'b1;
      rec          = 1'b1;
      ent          = '{valid: 1'b1, warn: 1'b0, code: gapc_alm_code(alarm_evt)};
      if (!s_reg.alm_on) begin
        s_next.alm_on   = 1'b1;
        s_next.alm_code = gapc_alm_code(alarm_evt);
      end
    end else if (|warn_evt) begin
      ev[ST_WARN]     = 1'b1;
      rec             = 1'b1;
      s_next.wrn_on   = 1'b1;
      s_next.wrn_code = warn_evt[0] ? WRN_RS485 : WRN_TOUT;
      ent = '{valid: 1'b1, warn: 1'b1, code: s_next.wrn_code};
    end

    // history: newest at index 0, oldest drops off the end
    if (rec) begin
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin
        s_next.hist[i] = s_reg.hist[i-1];
      end
      s_next.hist[0] = ent;
    end

    // traffic halt follows the alarm latch
    s_next.halt     = s_next.alm_on;
    s_next.conn_out = s_next.alm_on ? 16'h0 : s_next.conn_act;

    // scan time in ms between consecutive scan completions
    tick = s_reg.ms_div == 16'(MS_CYCLES - 1);
    s_next.ms_div = tick ? 16'h0 : s_reg.ms_div + 16'h1;
    if (tick && s_reg.scan_cnt != 16'hffff) begin
      s_next.scan_cnt = s_reg.scan_cnt + 16'h1;
    end
    if (scan_done) begin
      s_next.scan_ms  = s_next.scan_cnt;
      s_next.scan_cnt = 16'h0;
      ev[ST_SCAN]     = 1'b1;
    end

    // fieldbus memory work: start wins over a same-cycle done
    if (mem_done) s_next.busy = 1'b0;
    if (mem_start) s_next.busy = 1'b1;

    // lock is toggled by the setter after its own hold timing
    if (keys.lock_toggle && top) begin
      s_next.edit_en = ~s_reg.edit_en;
    end

    // menu navigation
    if (keys.key_mode && top) begin
      case (s_reg.mode)
        MODE_MON:   s_next.mode = MODE_PARAM;
        MODE_PARAM: s_next.mode = MODE_COPY;
        MODE_COPY:  s_next.mode = MODE_MON;
        default:    s_next.mode = MODE_MON;
      endcase
      s_next.disp = DISP_NONE;
    end else if (keys.key_esc && !top) begin
      s_next.lvl  = s_reg.lvl - 2'h1;
      s_next.disp = DISP_NONE;
    end else if (keys.key_set) begin
      s_next.disp = DISP_NONE;
      if (top && s_reg.mode != MODE_MON && lock) begin
        s_next.disp     = DISP_LOCK;
        ev[ST_REFUSE]   = 1'b1;
      end else if (top && s_reg.mode != MODE_MON && s_reg.busy) begin
        s_next.disp     = DISP_BUSY;
        ev[ST_REFUSE]   = 1'b1;
      end else if (s_reg.lvl != LVL_MAX) begin
        s_next.lvl = s_reg.lvl + 2'h1;
      end
    end

    // record clear: only reachable while the items are shown
    if (!s_reg.clr_act && !lock && s_reg.mode == MODE_MON &&
        (keys.clr_alarm || keys.clr_warn)) begin
      s_next.clr_act  = 1'b1;
      s_next.clr_warn = keys.clr_warn & ~keys.clr_alarm;
      s_next.clr_cnt  = 4'h0;
    end else if (s_reg.clr_act) begin
      s_next.clr_cnt = s_reg.clr_cnt + 4'h1;
      if (s_reg.clr_cnt == 4'(CLR_CYC - 1)) begin
        s_next.clr_act = 1'b0;
        ev[ST_CLRD]    = 1'b1;
        for (int i = 0; i < HIST_DEPTH; i++) begin
          if (s_next.hist[i].warn == s_reg.clr_warn) begin
            s_next.hist[i].valid = 1'b0;
          end
        end
        if (s_reg.clr_warn) s_next.wrn_on = 1'b0;
      end
    end

    // link failure overrides any other display
    if (link) s_next.disp = DISP_COMM;
    else if (s_reg.link_d) s_next.disp = DISP_NONE;
    ev[ST_LINK] = link & ~s_reg.link_d;

    // sticky status: a new event beats a same-cycle clear
    s_next.sts = (s_reg.sts & ~w1c) | ev;
    s_next.irq = |(s_next.sts & s_next.msk);
  end

  // packs the navigation view from a state value
  function automatic logic [15:0] view_bits(input gapc_state_t x);
    gapc_view_t v;
    v.mode        = x.mode;
    v.level       = x.lvl;
    v.disp        = x.disp;
    v.lock        = ~x.edit_en;
    v.clr_visible = x.edit_en;
    v.clr_busy    = x.clr_act;
    v.mem_busy    = x.busy;
    return {3'h0, v};
  endfunction

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg         <= '0;
      s_reg.msk     <= MASK_RST;
      s_reg.edit_en <= EDIT_RST;
      s_reg.mode    <= MODE_MON;
      s_reg.disp    <= DISP_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state register
  // ****************************************************************
  assign prdata     = s_reg.prdata;
  assign pready     = s_reg.pready;
  assign pslverr    = s_reg.pslverr;
  assign irq        = s_reg.irq;
  assign rs485_halt = s_reg.halt;
  assign conn_en    = s_reg.conn_out;
  // padded view word; only the low struct bits leave the block
  logic [15:0] view_w;
  assign view_w     = view_bits(s_reg);
  assign view       = gapc_view_t'(view_w[12:0]);
endmodule
`default_nettype wire

// File: verif/gapc_properties.sv
// checker: port-level properties of the alarm and parameter control block
`timescale 1ns/1ps
`default_nettype none
module gapc_properties
  import gapc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 link_fail,
  input wire gapc_pkg::gapc_keys_t keys,
  input wire logic                 mem_start,
  input wire logic [3:0]           alarm_evt,
  input wire logic                 rs485_halt,
  input wire logic [15:0]          conn_en,
  input wire gapc_pkg::gapc_view_t view
);
  logic [4:0] busy_cnt;
  // length of a running clear, judged when it ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 5'h00;
    end else begin
      busy_cnt <= view.clr_busy ? busy_cnt + 5'h01 : 5'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************************************
  // properties
  // ****************************************************************
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no zero-wait answer");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  halt_hold_a: assert property (rs485_halt |=> rs485_halt) else $error("halt dropped");
  halt_conn_a: assert property (rs485_halt |-> ##1 conn_en == 16'h0000) else $error("traffic while halted");
  alarm_halt_a: assert property (|alarm_evt |-> ##[1:2] rs485_halt) else $error("alarm did not halt");
  clr_hide_a: assert property (view.clr_visible == !view.lock) else $error("clear item shown under lock");
  clr_len_a: assert property ($fell(view.clr_busy) |-> busy_cnt == 5'h10) else $error("clear length");
  esc_back_a: assert property (keys.key_esc && !keys.key_mode && view.level != 2'h0
    |=> view.level == $past(view.level) - 2'h1) else $error("escape not one level");
  lock_refuse_a: assert property (keys.key_set && !keys.key_esc && !keys.key_mode && view.level == 2'h0
    && view.lock && view.mode != MODE_MON |=> view.disp == DISP_LOCK && view.level == 2'h0)
    else $error("locked select not refused");
  busy_refuse_a: assert property (keys.key_set && !keys.key_esc && !keys.key_mode && view.level == 2'h0
    && !view.lock && view.mem_busy && view.mode != MODE_MON |=> view.disp == DISP_BUSY && view.level == 2'h0)
    else $error("busy select not refused");
  mem_busy_a: assert property (mem_start |-> ##[1:2] view.mem_busy) else $error("memory busy missing");
  link_a: assert property ($rose(link_fail) |-> ##[1:5] view.disp == DISP_COMM) else $error("no link fault");
endmodule
`default_nettype wire

// File: verif/gapc_setter_model.sv
// partner: behavioural handheld setter that sends key pulses
`timescale 1ns/1ps
`default_nettype none
module gapc_setter_model
  import gapc_pkg::*;
#(
  parameter int HOLD_CYC = 20
) (
  input wire logic               clk,
  output var gapc_pkg::gapc_keys_t keys
);
  initial begin
    keys = '0;
  end
  // one key per press, a single clock wide
  task automatic push(input logic [5:0] k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= '0;
  endtask
  // the lock flips after a wait of HOLD_CYC clocks and a one-clock lock_toggle pulse, on a top screen
  task automatic lock_flip;
    repeat (HOLD_CYC) @(posedge clk);
    push(6'h04);
  endtask
endmodule
`default_nettype wire

// File: verif/gateway_alarm_param_control_test.sv
// testbench: alarm, warning and setter access control block
`timescale 1ns/1ps
`default_nettype none
module gateway_alarm_param_control_test;
  import gapc_pkg::*;
  localparam int MS = 10;
  localparam logic [5:0] K_SET = 6'h20, K_ESC = 6'h10, K_MODE = 6'h08, K_CLRW = 6'h01;
  logic        clk, rstn, psel, penable, pwrite, link_fail, mem_start, mem_done, scan_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, perr, irq, rs485_halt;
  logic [3:0]  alarm_evt;
  logic [1:0]  warn_evt, w;
  logic [15:0] boot_conn, conn_en;
  logic [9:0]  hist[$];
  logic [3:0]  alm[4] = '{4'h8, 4'h1, 4'h2, 4'h4};
  logic [7:0]  acode[4] = '{ALM_NODE, ALM_NVM, ALM_SWSET, ALM_RS485};
  gapc_keys_t  keys;
  gapc_view_t  view;
  int          fails, n_tests, n;
  gapc_top #(.MS_CYCLES(MS)) u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link_fail(link_fail), .keys(keys), .mem_start(mem_start), .mem_done(mem_done), .alarm_evt(alarm_evt),
    .warn_evt(warn_evt), .scan_done(scan_done), .boot_conn(boot_conn), .rs485_halt(rs485_halt),
    .conn_en(conn_en), .view(view));
  gapc_setter_model #(.HOLD_CYC(20)) u_set (.clk(clk), .keys(keys));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task close_out;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer; the answer is taken at the rising edge where pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      close_out;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task ev(input logic [3:0] a, input logic [1:0] wv, input logic [2:0] m);
    @(posedge clk);
    alarm_evt <= a;
    warn_evt <= wv;
    {mem_start, mem_done, scan_done} <= m;
    @(posedge clk);
    alarm_evt <= 4'h0;
    warn_evt <= 2'h0;
    {mem_start, mem_done, scan_done} <= 3'h0;
    @(negedge clk);
  endtask
  task key(input logic [5:0] k);
    u_set.push(k);
    @(negedge clk);
  endtask
  task rst_dut;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rstn, psel, penable, pwrite, link_fail, mem_start, mem_done, scan_done} = 8'h00;
    {paddr, pwdata, alarm_evt, warn_evt} = '0;
    fails = 0;
    n_tests = 0;
    void'($urandom(20975));
    boot_conn = 16'($urandom);
    rst_dut;
    chk(conn_en, boot_conn);
    rchk(OFS_CACT, {16'h0, boot_conn});
    rchk(OFS_MASK, 32'h0);
    chk({view.lock, view.clr_visible}, 2'h1);
    // stored enables do not reach the running copy, which keeps boot_conn
    apb(1'b1, OFS_CONN, {16'h0, ~boot_conn});
    rchk(OFS_CONN, {16'h0, ~boot_conn});
    rchk(OFS_CACT, {16'h0, boot_conn});
    apb(1'b1, 8'h40, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(rd, 32'h0);
    // level walk, set at the deepest level ignored
    for (int i = 1; i < 5; i++) begin
      key(K_SET);
      chk(view.level, (i > 3) ? 3 : i);
    end
    for (int i = 2; i >= 0; i--) begin
      key(K_ESC);
      chk(view.level, i);
    end
    u_set.lock_flip;
    @(negedge clk);
    chk({view.lock, view.clr_visible}, 2'h2);
    key(K_CLRW);
    chk(view.clr_busy, 1'b0);
    for (int i = 0; i < 2; i++) begin
      key(K_MODE);
      chk(view.mode, i ? MODE_COPY : MODE_PARAM);
      key(K_SET);
      chk({view.level, view.disp}, {2'h0, DISP_LOCK});
    end
    key(K_MODE);
    u_set.lock_flip;
    @(negedge clk);
    chk(view.lock, 1'b0);
    ev(4'h0, 2'h0, 3'h4);
    chk(view.mem_busy, 1'b1);
    key(K_MODE);
    key(K_SET);
    chk({view.level, view.disp}, {2'h0, DISP_BUSY});
    ev(4'h0, 2'h0, 3'h2);
    chk(view.mem_busy, 1'b0);
    key(K_SET);
    chk(view.level, 2'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_REFUSE], 1'b1);
    key(K_ESC);
    key(K_MODE);
    key(K_MODE);
    chk(view.mode, MODE_MON);
    // random warnings, both codes forced first
    for (int i = 0; i < 12; i++) begin
      w = (i < 2) ? (i ? 2'h2 : 2'h1) : (($urandom % 2) ? 2'h2 : 2'h1);
      ev(4'h0, w, 3'h0);
      hist.push_front({2'h3, w[0] ? WRN_RS485 : WRN_TOUT});
    end
    rchk(OFS_WARN, {23'h0, 1'b1, hist[0][7:0]});
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, OFS_HSEL, 32'(i));
      rchk(OFS_HDATA, (i < 10) ? {22'h0, hist[i]} : 32'h0);
    end
    chk(irq, 1'b0);
    apb(1'b1, OFS_MASK, 32'h2);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h3f);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    // unlocked clear, timed to its end
    key(K_CLRW);
    n = 0;
    while (view.clr_busy === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n, 16);
    apb(1'b1, OFS_HSEL, 32'h0);
    apb(1'b0, OFS_HDATA, 32'h0);
    chk(rd[9], 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_CLRD], 1'b1);
    // exactly five ms periods between the two scan ends, whatever the divider phase
    ev(4'h0, 2'h0, 3'h1);
    repeat (5 * MS - 2) @(posedge clk);
    ev(4'h0, 2'h0, 3'h1);
    rchk(OFS_SCAN, 32'h5);
    @(posedge clk);
    link_fail <= 1'b1;
    repeat (6) @(negedge clk);
    chk(view.disp, DISP_COMM);
    @(posedge clk);
    link_fail <= 1'b0;
    // every alarm cause; a warning alongside is dropped
    for (int j = 0; j < 4; j++) begin
      ev(alm[j], 2'h1, 3'h0);
    end
    rchk(OFS_ALARM, {23'h0, 1'b1, ALM_NODE});
    chk({rs485_halt, conn_en}, 17'h10000);
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, OFS_HSEL, 32'(j));
      rchk(OFS_HDATA, {22'h0, 2'h2, acode[3 - j]});
    end
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    repeat (2) @(negedge clk);
    chk(rs485_halt, 1'b1);
    rchk(OFS_ALARM, {23'h0, 1'b1, ALM_NODE});
    rst_dut;
    chk(rs485_halt, 1'b0);
    rchk(OFS_HDATA, 32'h0);
    rchk(OFS_WARN, 32'h0);
    close_out;
  end
endmodule
bind gapc_top gapc_properties u_props (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .link_fail(link_fail), .keys(keys), .mem_start(mem_start),
  .alarm_evt(alarm_evt), .rs485_halt(rs485_halt), .conn_en(conn_en), .view(view));
`default_nettype wire
